// File: common/bjs_pkg.sv
`default_nettype none
package bjs_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_HZ = 4_000_000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int CNT_W = 24;
    localparam int ST_W = 4;
    localparam int N_CMP = 16;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0c;
    localparam logic [7:0] A_ACK = 8'h10;
    localparam logic [7:0] A_COUNT = 8'h14;
    localparam logic [7:0] A_CMP_BASE = 8'h40;
    localparam int C_RUN = 0;
    localparam int C_LINE = 1;
    localparam int C_FALL = 2;
    localparam int C_LAMDIS = 3;
    localparam int C_MAX_LO = 4;
    localparam int S_LAM = 0;
    localparam int S_CYC = 1;
    localparam int S_OVF = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0060;
    typedef enum logic [3:0] {
        BJS_IDLE = 4'b0001,
        BJS_WAIT_LINE = 4'b0010,
        BJS_RUN = 4'b0100,
        BJS_WAIT_ACK = 4'b1000
    } bjs_state_t;
endpackage : bjs_pkg
`default_nettype wire

// File: src/bjs_seq_timer.sv
// Decided for this implementation: the APB slave port and the address map.
`default_nettype none
module bjs_seq_timer
    import bjs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_zc,
    output logic [ST_W-1:0] state_num_q,
    output logic lam_q,
    output logic irq_q
);
    logic [31:0] ctrl_q;
    logic [CNT_W-1:0] cmp_q [N_CMP];
    logic [CNT_W-1:0] count_q;
    logic [7:0] div_q;
    logic tick;
    logic line_q;
    logic zc_edge;
    logic [2:0] istat_q;
    logic [2:0] imask_q;
    logic [2:0] ev;
    logic ack_wr;
    logic cyc_end;
    logic [ST_W-1:0] max_st;
    bjs_state_t st_q;

    wire logic acc = psel && penable;
    // Writes commit only on the completing edge, so a held access is not applied twice
    wire logic wr = acc && pready && pwrite;
    // Read side effects go with the edge that captures prdata, so no event is lost unseen
    wire logic rd = acc && !pready && !pwrite;
    wire logic cmp_hit = paddr >= A_CMP_BASE && paddr < A_CMP_BASE + 8'(4 * N_CMP) && paddr[1:0] == 2'b00;
    wire logic [ST_W-1:0] cmp_idx = paddr[ST_W+1:2];

    assign max_st = ctrl_q[C_MAX_LO +: ST_W];
    assign ack_wr = wr && paddr == A_ACK;

    // Tick divider: one enable per 4 MHz period
    always_ff @(posedge sys_clk) begin
        if (srst || div_q == 8'(TICK_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign tick = (div_q == 8'(TICK_DIV - 1));

    // A late or doubled tick would skew every state interval
    a_tick_single: assert property (@(posedge sys_clk) disable iff (srst)
        tick
        |=> !tick)
        else $error("tick lasted more than one clock");

    a_tick_period: assert property (@(posedge sys_clk) disable iff (srst)
        tick
        |-> ##50 tick)
        else $error("tick period wrong");

    a_div_bound: assert property (@(posedge sys_clk) disable iff (srst)
        1'b1
        |-> div_q < 8'(TICK_DIV))
        else $error("divider out of range");

    // Zero-crossing edge; polarity is selectable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            line_q <= 1'b0;
        end else begin
            line_q <= line_zc;
        end
    end
    assign zc_edge = ctrl_q[C_FALL] ? (line_q && !line_zc) : (!line_q && line_zc);

    assign cyc_end = st_q == BJS_RUN && tick && count_q > cmp_q[state_num_q] && state_num_q == max_st;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            imask_q <= 3'h0;
        end else if (wr && paddr == A_CTRL) begin
            ctrl_q <= pwdata;
        end else if (wr && paddr == A_IRQ_MASK) begin
            imask_q <= pwdata[2:0];
        end
    end

    // Comparator bank, one word per state
    genvar gi;
    generate
        for (gi = 0; gi < N_CMP; gi++) begin : g_cmp
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    cmp_q[gi] <= '0;
                end else if (wr && cmp_hit && cmp_idx == ST_W'(gi)) begin
                    cmp_q[gi] <= pwdata[CNT_W-1:0];
                end
            end
        end
    endgenerate

    // Sequencer
    always_ff @(posedge sys_clk) begin
        if (srst || !ctrl_q[C_RUN]) begin
            st_q <= BJS_IDLE;
            count_q <= '0;
            state_num_q <= '0;
            lam_q <= 1'b0;
        end else begin
            unique case (st_q)
                BJS_IDLE: begin
                    st_q <= ctrl_q[C_LINE] ? BJS_WAIT_LINE : BJS_RUN;
                    count_q <= '0;
                end
                BJS_WAIT_LINE: begin
                    count_q <= '0;
                    state_num_q <= '0;
                    if (zc_edge) begin
                        st_q <= BJS_RUN;
                    end
                end
                BJS_RUN: begin
                    if (cyc_end) begin
                        state_num_q <= '0;
                        count_q <= '0;
                        if (ctrl_q[C_LAMDIS]) begin
                            st_q <= ctrl_q[C_LINE] ? BJS_WAIT_LINE : BJS_RUN;
                        end else begin
                            lam_q <= 1'b1;
                            st_q <= BJS_WAIT_ACK;
                        end
                    end else if (tick) begin
                        count_q <= count_q + 1'b1;
                        // State 0 interval gives the predelay before active states
                        if (count_q > cmp_q[state_num_q]) begin
                            state_num_q <= state_num_q + 1'b1;
                        end
                    end
                end
                BJS_WAIT_ACK: begin
                    if (ack_wr || ctrl_q[C_LAMDIS]) begin
                        lam_q <= 1'b0;
                        count_q <= '0;
                        st_q <= ctrl_q[C_LINE] ? BJS_WAIT_LINE : BJS_RUN;
                    end
                end
            endcase
        end
    end

    // Sticky events: set wins over read-clear
    assign ev[S_LAM] = cyc_end && !ctrl_q[C_LAMDIS];
    assign ev[S_CYC] = cyc_end;
    assign ev[S_OVF] = st_q == BJS_RUN && tick && count_q == '1;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            istat_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            istat_q <= ((rd && paddr == A_IRQ_STAT) ? 3'h0 : istat_q) | ev;
            irq_q <= |(istat_q & imask_q);
        end
    end

    // APB: one-wait-state answers, slverr on unmapped addresses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !pready && !penable ? 1'b0 : (psel && penable && !pready);
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && penable && !pready) begin
                unique case (1'b1)
                    paddr == A_CTRL: prdata <= ctrl_q;
                    paddr == A_STATUS: prdata <= {24'h0, state_num_q, st_q};
                    paddr == A_IRQ_STAT: prdata <= {29'h0, istat_q};
                    paddr == A_IRQ_MASK: prdata <= {29'h0, imask_q};
                    paddr == A_ACK: prdata <= {31'h0, lam_q};
                    paddr == A_COUNT: prdata <= {8'h0, count_q};
                    cmp_hit: prdata <= {8'h0, cmp_q[cmp_idx]};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    a_lam_holds: assert property (@(posedge sys_clk) disable iff (srst)
        lam_q && !ack_wr && ctrl_q[C_RUN] && !ctrl_q[C_LAMDIS] |=> lam_q)
        else $error("lam dropped without ack");
    a_idle_zero: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_WAIT_ACK |-> state_num_q == '0)
        else $error("rest state not zero");
    a_state_adv: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_RUN && tick && !cyc_end && count_q <= cmp_q[state_num_q] && ctrl_q[C_RUN]
        |=> $stable(state_num_q))
        else $error("state advanced early");

    // Steps of a cycle; run must be set or the sequencer is held in reset
    sequence s_run_tick;
        st_q == BJS_RUN && tick && ctrl_q[C_RUN];
    endsequence

    sequence s_cycle_close;
        st_q == BJS_RUN && cyc_end && ctrl_q[C_RUN];
    endsequence

    sequence s_line_armed;
        st_q == BJS_WAIT_LINE && ctrl_q[C_RUN];
    endsequence

    property p_lam_handshake;
        @(posedge sys_clk) disable iff (srst) s_cycle_close ##0 !ctrl_q[C_LAMDIS] |=> lam_q && st_q == BJS_WAIT_ACK;
    endproperty

    a_lam_raise: assert property (p_lam_handshake)
        else $error("lam not raised at cycle end");

    a_count_clear: assert property (@(posedge sys_clk) disable iff (srst)
        s_cycle_close
        |=> count_q == '0)
        else $error("counter not cleared at cycle start");

    a_count_step: assert property (@(posedge sys_clk) disable iff (srst)
        s_run_tick ##0 !cyc_end
        |=> count_q == $past(count_q) + 1'b1)
        else $error("counter missed a tick");

    a_count_hold: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_RUN && !tick && ctrl_q[C_RUN]
        |=> $stable(count_q) && st_q == BJS_RUN)
        else $error("counter moved between ticks");

    a_state_step: assert property (@(posedge sys_clk) disable iff (srst)
        s_run_tick ##0 (!cyc_end && count_q > cmp_q[state_num_q])
        |=> state_num_q == $past(state_num_q) + 1'b1)
        else $error("state did not advance");

    a_predelay_hold: assert property (@(posedge sys_clk) disable iff (srst)
        s_run_tick ##0 (state_num_q == '0 && count_q <= cmp_q[0])
        |=> state_num_q == '0)
        else $error("predelay cut short");

    a_cycle_rest: assert property (@(posedge sys_clk) disable iff (srst)
        s_cycle_close
        |=> state_num_q == '0)
        else $error("no rest state after cycle end");

    a_lamdis_skip: assert property (@(posedge sys_clk) disable iff (srst)
        s_cycle_close ##0 ctrl_q[C_LAMDIS]
        |=> !lam_q && st_q != BJS_WAIT_ACK)
        else $error("waited for ack with lam disabled");

    a_free_restart: assert property (@(posedge sys_clk) disable iff (srst)
        s_cycle_close ##0 (ctrl_q[C_LAMDIS] && !ctrl_q[C_LINE])
        |=> st_q == BJS_RUN)
        else $error("free run did not restart");

    a_ack_restart: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_WAIT_ACK && ack_wr && ctrl_q[C_RUN] && !ctrl_q[C_LINE]
        |=> st_q == BJS_RUN)
        else $error("no restart after ack");

    a_ack_halt: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_WAIT_ACK && !ack_wr && ctrl_q[C_RUN] && !ctrl_q[C_LAMDIS]
        |=> st_q == BJS_WAIT_ACK && $stable(count_q))
        else $error("sequencer moved without ack");

    a_line_wait: assert property (@(posedge sys_clk) disable iff (srst)
        s_line_armed ##0 !zc_edge
        |=> st_q == BJS_WAIT_LINE && count_q == '0)
        else $error("cycle started without line edge");

    a_line_start: assert property (@(posedge sys_clk) disable iff (srst)
        s_line_armed ##0 zc_edge
        |=> st_q == BJS_RUN && count_q == '0)
        else $error("line edge did not start cycle");

    a_ack_release: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_WAIT_ACK && ack_wr && ctrl_q[C_RUN]
        |=> !lam_q)
        else $error("lam kept after ack");

    a_lam_only_wait: assert property (@(posedge sys_clk) disable iff (srst)
        lam_q
        |-> st_q == BJS_WAIT_ACK)
        else $error("lam outside ack wait");

    a_wait_line_zero: assert property (@(posedge sys_clk) disable iff (srst)
        st_q == BJS_WAIT_LINE
        |-> state_num_q == '0)
        else $error("line wait not at state zero");

    a_run_off: assert property (@(posedge sys_clk) disable iff (srst)
        !ctrl_q[C_RUN]
        |=> st_q == BJS_IDLE && !lam_q && state_num_q == '0)
        else $error("stopped sequencer not at rest");

    a_onehot: assert property (@(posedge sys_clk) disable iff (srst)
        1'b1
        |-> $onehot(st_q))
        else $error("sequencer state not one-hot");

    // Downstream modules decode the cable at any time, so it may only move on a tick
    a_cable_stable: assert property (@(posedge sys_clk) disable iff (srst)
        ctrl_q[C_RUN] && !(st_q == BJS_RUN && tick)
        |=> $stable(state_num_q))
        else $error("state number changed off tick");

    a_irq_high: assert property (@(posedge sys_clk) disable iff (srst)
        |(istat_q & imask_q)
        |=> irq_q)
        else $error("irq missing");

    a_irq_low: assert property (@(posedge sys_clk) disable iff (srst)
        !(|(istat_q & imask_q))
        |=> !irq_q)
        else $error("irq without cause");

    a_sticky_set: assert property (@(posedge sys_clk) disable iff (srst)
        ev[S_LAM]
        |=> istat_q[S_LAM])
        else $error("lam event lost");

    a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        ev[S_OVF]
        |=> istat_q[S_OVF])
        else $error("overflow event lost");

    a_cyc_clear: assert property (@(posedge sys_clk) disable iff (srst)
        rd && paddr == A_IRQ_STAT && !ev[S_CYC]
        |=> !istat_q[S_CYC])
        else $error("status read did not clear");

    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr && paddr == A_CTRL
        |=> ctrl_q == $past(pwdata))
        else $error("control write lost");

    a_mask_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr && paddr == A_IRQ_MASK
        |=> imask_q == 3'($past(pwdata)))
        else $error("mask write lost");

    // Bus answer shape: one wait state, then a single-cycle answer
    a_apb_wait: assert property (@(posedge sys_clk) disable iff (srst)
        psel && penable && !pready
        |=> pready)
        else $error("no answer after wait state");

    a_apb_pulse: assert property (@(posedge sys_clk) disable iff (srst)
        pready
        |=> !pready)
        else $error("ready held too long");

    a_err_with_ready: assert property (@(posedge sys_clk) disable iff (srst)
        pslverr
        |-> pready)
        else $error("error without ready");

    a_rdata_quiet: assert property (@(posedge sys_clk) disable iff (srst)
        !pready
        |-> prdata == 32'h0)
        else $error("read data outside answer");
endmodule : bjs_seq_timer
`default_nettype wire

// File: test/bjs_line_src.sv
`default_nettype none
module bjs_line_src (
    input wire logic sys_clk,
    input wire logic en,
    output logic line_zc
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial line_zc = 1'b0;
    // Mains stand-in: a level change every 400 clocks, parked low when disabled
    always @(posedge sys_clk) begin
        cnt <= (cnt == 399) ? 0 : cnt + 1;
        if (cnt == 399) line_zc <= en ? ~line_zc : 1'b0;
    end
endmodule : bjs_line_src
`default_nettype wire

// File: test/tb.sv
`default_nettype none
module tb
    import bjs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lsrc_en = 1'b0;
    logic [7:0] paddr = 8'h00, rnd = 8'h3b;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, line_zc, lam_q, irq_q, err_q;
    logic [3:0] state_num_q, st_prev = 4'h0;
    int fail_count = 0, samples_checked = 0, dur = 0, d1 = 0, d2 = 0, n1 = 0, n0 = 0, cmp[3];
    always #2.5 sys_clk = ~sys_clk;
    bjs_seq_timer uut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_zc(line_zc), .state_num_q(state_num_q), .lam_q(lam_q), .irq_q(irq_q));
    bjs_line_src lsrc (.sys_clk(sys_clk), .en(lsrc_en), .line_zc(line_zc));
    // Model of the cable: clocks spent in states 1 and 2, and cycle starts seen
    always @(posedge sys_clk) begin
        st_prev <= state_num_q;
        if (state_num_q != st_prev) begin
            if (st_prev == 4'h1) d1 <= dur;
            if (st_prev == 4'h2) d2 <= dur;
            if (state_num_q == 4'h1) n1 <= n1 + 1;
            dur <= 1;
        end else dur <= dur + 1;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : waitc
    // Waits an edge first so two back-to-back calls never drive psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        waitc(40000);
        fail_count++;
        test_done();
    end
    initial begin
        waitc(20);
        srst <= 1'b0;
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd_q, CTRL_RST);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            cmp[k] = (k > 0 ? cmp[k - 1] : 0) + 1 + int'(rnd[1:0]);
            apb(1'b1, A_CMP_BASE + 8'(4 * k), 32'(cmp[k]));
        end
        apb(1'b1, A_IRQ_MASK, 32'h1);
        apb(1'b1, A_CTRL, 32'h21);
        for (int n = 0; n < 3000 && lam_q !== 1'b1; n++) waitc(1);
        waitc(2);
        chk({31'h0, lam_q}, 32'h1);
        chk(32'(d1), 32'((cmp[1] - cmp[0]) * TICK_DIV));
        chk(32'(d2), 32'((cmp[2] - cmp[1]) * TICK_DIV));
        chk({31'h0, irq_q}, 32'h1);
        waitc(300);
        chk({28'h0, state_num_q}, 32'h0);
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(rd_q & 32'h1, 32'h1);
        apb(1'b0, A_IRQ_STAT, 32'h0);
        chk(rd_q & 32'h1, 32'h0);
        apb(1'b1, A_ACK, 32'h0);
        waitc(4);
        chk({30'h0, lam_q, irq_q}, 32'h0);
        $display("test 1 done");
        apb(1'b1, A_CTRL, 32'h29);
        n0 = n1;
        waitc(3000);
        chk(32'(n1 - n0 > 2), 32'h1);
        chk({31'h0, lam_q}, 32'h0);
        $display("test 2 done");
        for (int i = 0; i < 2; i++) begin
            lsrc_en <= 1'b0;
            apb(1'b1, A_CTRL, (i == 1) ? 32'h2f : 32'h2b);
            // Parking the line low may itself make one edge, so let that cycle drain
            waitc(1500);
            n0 = n1;
            waitc(1500);
            chk(32'(n1 - n0), 32'h0);
            chk({28'h0, state_num_q}, 32'h0);
            lsrc_en <= 1'b1;
            waitc(1500);
            chk(32'(n1 > n0), 32'h1);
        end
        $display("test 3 done");
        apb(1'b0, 8'h30, 32'h0);
        chk({err_q, rd_q[30:0]}, 32'h8000_0000);
        $display("test 4 done");
        test_done();
    end
endmodule : tb
`default_nettype wire
